// >>> hdl/scs_map.vh
// scs_map.vh: register map, field positions, reset values and timing counts
// assumes: included by the sample clock sync design files
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// register addresses on the serial port
`define SCS_ADDR_EXT_CFG 4'h9
`define SCS_ADDR_FINE 4'hE
`define SCS_ADDR_COARSE 4'hF

// reset values
`define SCS_RST_EXT_CFG 16'h03FF
`define SCS_RST_FINE 16'h00FF
`define SCS_RST_COARSE 16'h007F

// field positions
`define SCS_EXT_PATTERN_BIT 15
`define SCS_EXT_STROBE_RUN_BIT 14
`define SCS_FINE_HI 15
`define SCS_FINE_LO 8
`define SCS_INVERT_BIT 15
`define SCS_COARSE_HI 14
`define SCS_COARSE_LO 10
`define SCS_INT_HI 9
`define SCS_INT_LO 7

// serial frame: address bits then data bits, msb first
`define SCS_FRAME_BITS 5'd20

// delay steps
`define SCS_COARSE_STEP_PS 65
`define SCS_INT_STEP_PS 11
`define SCS_FINE_FULL_TENTHS 500
`define SCS_FINE_FULL_CODE 255

// restart waits after the captured release, in sample clocks
`define SCS_WAIT_DEMUX0 3'd4
`define SCS_WAIT_OTHER 3'd3

// clock to strobe delay and clock period
`define SCS_TOD_PS 4000
`define SCS_CLK_PS 10000
`define SCS_TOD_CYC ((`SCS_TOD_PS + `SCS_CLK_PS - 1) / `SCS_CLK_PS)

// pattern words
`define SCS_PAT_LO_QD 7'h00
`define SCS_PAT_LO_ID 7'h01
`define SCS_PAT_LO_Q 7'h01
`define SCS_PAT_LO_I 7'h02
`define SCS_PAT_HI_QD 7'h7F
`define SCS_PAT_HI_ID 7'h7E
`define SCS_PAT_HI_Q 7'h7E
`define SCS_PAT_HI_I 7'h7D
`define SCS_PAT_ND_LO_Q 7'h00
`define SCS_PAT_ND_LO_I 7'h01
`define SCS_PAT_ND_HI_Q 7'h7F
`define SCS_PAT_ND_HI_I 7'h7E
`define SCS_PAT_LEN_DEMUX 4'd5
`define SCS_PAT_LEN_NODEMUX 4'd12
`define SCS_PAT_SEQ_DEMUX 5'h0A
`define SCS_PAT_SEQ_NODEMUX 12'h932

`endif

// >>> hdl/scs_pattern_gen.v
// scs_pattern_gen: test pattern table and sequencer with registered outputs
// assumes: advance is a one-cycle enable per output word slot
`timescale 1ns/10ps
`include "scs_map.vh"

module scs_pattern_gen (
    // clock and reset
    input wire sys_clk_i,
    input wire reset_n_i,
    // control
    input wire restart_i,
    input wire advance_i,
    input wire demux_i,
    // pattern words
    output reg [6:0] quadrature_delayed_bus_o,
    output reg [6:0] inphase_delayed_bus_o,
    output reg [6:0] q_bus_o,
    output reg [6:0] i_bus_o,
    output reg over_range_o
);

    reg [3:0] index_ff;
    reg [3:0] nxt_index;
    reg high;

    // sequence bit for a step: one means the high words
    function pat_high;
        input dmx;
        input [3:0] idx;
        reg [11:0] seq;
        begin
            seq = dmx ? {7'h00, `SCS_PAT_SEQ_DEMUX} : `SCS_PAT_SEQ_NODEMUX;
            pat_high = seq[idx];
        end
    endfunction

    always @* begin
        nxt_index = index_ff;
        if (restart_i) begin
            nxt_index = 4'h0;
        end else if (advance_i) begin
            // wraps forever, whether or not the pattern is selected
            if (index_ff >= (demux_i ? `SCS_PAT_LEN_DEMUX : `SCS_PAT_LEN_NODEMUX) - 4'h1) begin
                nxt_index = 4'h0;
            end else begin
                nxt_index = index_ff + 4'h1;
            end
        end
        high = pat_high(demux_i, nxt_index);
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index_ff <= 4'h0;
            quadrature_delayed_bus_o <= 7'h00;
            inphase_delayed_bus_o <= 7'h00;
            q_bus_o <= 7'h00;
            i_bus_o <= 7'h00;
            over_range_o <= 1'b0;
        end else begin
            index_ff <= nxt_index;
            over_range_o <= high;
            if (demux_i) begin
                quadrature_delayed_bus_o <= high ? `SCS_PAT_HI_QD : `SCS_PAT_LO_QD;
                inphase_delayed_bus_o <= high ? `SCS_PAT_HI_ID : `SCS_PAT_LO_ID;
                q_bus_o <= high ? `SCS_PAT_HI_Q : `SCS_PAT_LO_Q;
                i_bus_o <= high ? `SCS_PAT_HI_I : `SCS_PAT_LO_I;
            end else begin
                // delayed ports carry nothing in non-demux mode
                quadrature_delayed_bus_o <= 7'h00;
                inphase_delayed_bus_o <= 7'h00;
                q_bus_o <= high ? `SCS_PAT_ND_HI_Q : `SCS_PAT_ND_LO_Q;
                i_bus_o <= high ? `SCS_PAT_ND_HI_I : `SCS_PAT_ND_LO_I;
            end
        end
    end

endmodule // scs_pattern_gen

// >>> hdl/scs_sample_sync.v
// scs_sample_sync: phase adjust registers, strobe align, strobe gating, test pattern mux
// assumes: sys_clk_i is the sample clock; pins from the controller are asynchronous
//
// Contract
// - fine field 15:8 sets sample delay linearly, 0 none, FFh about 50 ps
// - coarse register bit 15 inverts sampling clock, clear after reset
// - coarse field 14:10 adds about 65 ps per code, reset zero
// - intermediate field 9:7 adds about 11 ps per code, total near 2.1 ns
// - strobe invalid while a register word shifts in, valid once latched
// - strobe held at a mode-dependent level while align pulse asserted
// - align release taken only at the next sample clock falling edge; here the two-stage synchroniser delay stands in for it
// - wait four clocks in demux 0-degree mode, else three, then clock-to-strobe delay
// - after the wait the strobe phase is realigned identically on all devices
// - strobe stops during calibration unless continuous strobe is set
// - pattern mode drives all ports and over-range from the generator
// - demux pattern words 00/01/01/02 low, 7F/7E/7E/7D high, flag follows high
// - non-demux Q 00/7F, I 01/7E, flag set with high words
// - pattern without align may leave one port pair a strobe behind
// - holding align while enabling pattern starts all ports at release
// - pattern advances every clock in non-demux mode, every other clock in demux mode
// - extended config bit 15 selects pattern source, clear after reset
`timescale 1ns/10ps
`include "scs_map.vh"

module scs_sample_sync #(
    parameter TOD_CYCLES = `SCS_TOD_CYC
) (
    // clock and reset
    input wire sys_clk_i,
    input wire reset_n_i,
    // serial register port
    input wire reg_select_n_i,
    input wire reg_sclk_i,
    input wire reg_sdata_i,
    // mode pins
    input wire demux_en_i,
    input wire ddr_en_i,
    input wire demux_zero_phase_i,
    input wire output_edge_i,
    // align and calibration
    input wire strobe_align_pulse_i,
    input wire calibration_active_i,
    // converter data
    input wire [6:0] adc_qd_i,
    input wire [6:0] adc_id_i,
    input wire [6:0] adc_q_i,
    input wire [6:0] adc_i_i,
    input wire adc_or_i,
    // sample clock adjust
    output wire [7:0] fine_code_o,
    output wire [8:0] fine_delay_tenth_ps_o,
    output wire [4:0] coarse_code_o,
    output wire [2:0] int_code_o,
    output wire [11:0] coarse_delay_ps_o,
    output wire sample_edge_invert_o,
    // output ports
    output reg output_data_strobe_o,
    output wire strobe_valid_o,
    output reg [6:0] quadrature_delayed_bus_o,
    output reg [6:0] inphase_delayed_bus_o,
    output reg [6:0] q_bus_o,
    output reg [6:0] i_bus_o,
    output reg over_range_o,
    output wire pattern_source_select_o
);

    localparam [4:0] ST_RUN = 5'b00001;
    localparam [4:0] ST_HOLD = 5'b00010;
    localparam [4:0] ST_WAIT = 5'b00100;
    localparam [4:0] ST_TOD = 5'b01000;
    localparam [4:0] ST_ALIGN = 5'b10000;

    // two-stage synchronisers for all pins but reset and the converter data
    reg [8:0] sync1_ff;
    reg [8:0] sync2_ff;
    wire sel_n = sync2_ff[0];
    wire sclk = sync2_ff[1];
    wire sdata = sync2_ff[2];
    wire demux = sync2_ff[3];
    wire ddr = sync2_ff[4];
    wire zero_phase = sync2_ff[5];
    wire out_edge = sync2_ff[6];
    wire align = sync2_ff[7];
    wire cal = sync2_ff[8];

    reg sclk_d_ff;
    reg sel_n_d_ff;
    reg [19:0] shift_ff;
    reg [4:0] bits_ff;
    reg [15:0] ext_cfg_ff;
    reg [15:0] fine_ff;
    reg [15:0] coarse_ff;

    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    reg slot_ff;
    reg pat_en_d_ff;
    reg nxt_strobe;

    wire writing;
    wire cal_stop;
    wire hold_level;
    wire word_slot;
    wire pat_restart;
    wire [6:0] pg_qd;
    wire [6:0] pg_id;
    wire [6:0] pg_q;
    wire [6:0] pg_i;
    wire pg_or;

    // tenths of a picosecond for a fine code
    function [8:0] fine_tenths;
        input [7:0] code;
        reg [31:0] prod;
        reg [31:0] quot;
        begin
            prod = code * `SCS_FINE_FULL_TENTHS;
            quot = prod / `SCS_FINE_FULL_CODE;
            // at most 500, so the dropped upper bits are always zero
            fine_tenths = quot[8:0];
        end
    endfunction

    // coarse plus intermediate delay in picoseconds
    function [11:0] coarse_ps;
        input [4:0] crs;
        input [2:0] itm;
        reg [31:0] sum;
        begin
            sum = crs * `SCS_COARSE_STEP_PS + itm * `SCS_INT_STEP_PS;
            coarse_ps = sum[11:0];
        end
    endfunction

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_ff <= 9'h001;
            sync2_ff <= 9'h001;
        end else begin
            sync1_ff <= {calibration_active_i, strobe_align_pulse_i, output_edge_i, demux_zero_phase_i,
                         ddr_en_i, demux_en_i, reg_sdata_i, reg_sclk_i, reg_select_n_i};
            sync2_ff <= sync1_ff;
        end
    end

    // serial port: bits shift on the rising serial clock, word latched when select rises
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_d_ff <= 1'b0;
            sel_n_d_ff <= 1'b1;
            shift_ff <= 20'h00000;
            bits_ff <= 5'h00;
            ext_cfg_ff <= `SCS_RST_EXT_CFG;
            fine_ff <= `SCS_RST_FINE;
            coarse_ff <= `SCS_RST_COARSE;
        end else begin
            sclk_d_ff <= sclk;
            sel_n_d_ff <= sel_n;
            if (sel_n) begin
                bits_ff <= 5'h00;
            end else if (sclk && !sclk_d_ff) begin
                shift_ff <= {shift_ff[18:0], sdata};
                if (bits_ff != 5'h1F) begin
                    bits_ff <= bits_ff + 5'h01;
                end
            end
            // a short or long frame is dropped whole, the old value stays
            if (sel_n && !sel_n_d_ff && bits_ff == `SCS_FRAME_BITS) begin
                case (shift_ff[19:16])
                    `SCS_ADDR_EXT_CFG: ext_cfg_ff <= shift_ff[15:0];
                    `SCS_ADDR_FINE: fine_ff <= shift_ff[15:0];
                    `SCS_ADDR_COARSE: coarse_ff <= shift_ff[15:0];
                    default: ext_cfg_ff <= ext_cfg_ff;
                endcase
            end
        end
    end

    // low filler bits are stored but steer nothing
    assign fine_code_o = fine_ff[`SCS_FINE_HI:`SCS_FINE_LO];
    assign fine_delay_tenth_ps_o = fine_tenths(fine_code_o);
    assign coarse_code_o = coarse_ff[`SCS_COARSE_HI:`SCS_COARSE_LO];
    assign int_code_o = coarse_ff[`SCS_INT_HI:`SCS_INT_LO];
    assign coarse_delay_ps_o = coarse_ps(coarse_code_o, int_code_o);
    assign sample_edge_invert_o = coarse_ff[`SCS_INVERT_BIT];
    assign pattern_source_select_o = ext_cfg_ff[`SCS_EXT_PATTERN_BIT];

    assign writing = !sel_n;
    // the controller keeps align low during calibration, so no arbitration here
    assign cal_stop = cal && !ext_cfg_ff[`SCS_EXT_STROBE_RUN_BIT];
    assign hold_level = ddr ? 1'b0 : out_edge;
    assign word_slot = demux ? slot_ff : 1'b1;

    // align sequencer; the synchroniser delay stands in for the falling-edge capture
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (align) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!align) begin
                    nxt_state = ST_WAIT;
                    nxt_cnt = {5'h00, (demux && zero_phase) ? `SCS_WAIT_DEMUX0 : `SCS_WAIT_OTHER};
                end
            end
            ST_WAIT: begin
                if (align) begin
                    nxt_state = ST_HOLD;
                end else if (cnt_ff <= 8'h01) begin
                    nxt_state = ST_TOD;
                    nxt_cnt = TOD_CYCLES[7:0];
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            ST_TOD: begin
                if (align) begin
                    nxt_state = ST_HOLD;
                end else if (cnt_ff <= 8'h01) begin
                    nxt_state = ST_ALIGN;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            ST_ALIGN: begin
                nxt_state = align ? ST_HOLD : ST_RUN;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always @* begin
        nxt_strobe = output_data_strobe_o;
        if (state_ff != ST_RUN) begin
            nxt_strobe = hold_level;
        end else if (writing || cal_stop) begin
            nxt_strobe = output_data_strobe_o;
        end else if (!ddr || word_slot) begin
            nxt_strobe = !output_data_strobe_o;
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_RUN;
            cnt_ff <= 8'h00;
            slot_ff <= 1'b0;
            output_data_strobe_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            output_data_strobe_o <= nxt_strobe;
            // every device restarts its slot phase on the same edge
            if (state_ff == ST_ALIGN) begin
                slot_ff <= 1'b0;
            end else begin
                slot_ff <= !slot_ff;
            end
        end
    end

    assign strobe_valid_o = (state_ff == ST_RUN) && !writing && !cal_stop;

    // generator restarts on enable and is held at its first step while align is up
    assign pat_restart = (state_ff != ST_RUN) || (pattern_source_select_o && !pat_en_d_ff);

    scs_pattern_gen u_pattern (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .restart_i(pat_restart),
        .advance_i(word_slot),
        .demux_i(demux),
        .quadrature_delayed_bus_o(pg_qd),
        .inphase_delayed_bus_o(pg_id),
        .q_bus_o(pg_q),
        .i_bus_o(pg_i),
        .over_range_o(pg_or)
    );

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pat_en_d_ff <= 1'b0;
            quadrature_delayed_bus_o <= 7'h00;
            inphase_delayed_bus_o <= 7'h00;
            q_bus_o <= 7'h00;
            i_bus_o <= 7'h00;
            over_range_o <= 1'b0;
        end else begin
            pat_en_d_ff <= pattern_source_select_o;
            if (pattern_source_select_o) begin
                quadrature_delayed_bus_o <= pg_qd;
                inphase_delayed_bus_o <= pg_id;
                q_bus_o <= pg_q;
                i_bus_o <= pg_i;
                over_range_o <= pg_or;
            end else begin
                quadrature_delayed_bus_o <= adc_qd_i;
                inphase_delayed_bus_o <= adc_id_i;
                q_bus_o <= adc_q_i;
                i_bus_o <= adc_i_i;
                over_range_o <= adc_or_i;
            end
        end
    end

endmodule // scs_sample_sync

// >>> bench/scs_checker.sv
// scs_checker: port assertions for scs_sample_sync
// assumes: mode pins change only while the align pulse is held
`timescale 1ns/10ps
module scs_checker (
    // clock, reset and pins
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire reg_select_n_i,
    input wire ddr_en_i,
    input wire output_edge_i,
    input wire strobe_align_pulse_i,
    input wire calibration_active_i,
    input wire [6:0] adc_q_i,
    // outputs watched
    input wire [7:0] fine_code_o,
    input wire [8:0] fine_delay_tenth_ps_o,
    input wire [4:0] coarse_code_o,
    input wire [2:0] int_code_o,
    input wire [11:0] coarse_delay_ps_o,
    input wire output_data_strobe_o,
    input wire strobe_valid_o,
    input wire [6:0] q_bus_o,
    input wire [6:0] i_bus_o,
    input wire over_range_o,
    input wire pattern_source_select_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_fine_span;
        (fine_code_o == 8'h00 |-> fine_delay_tenth_ps_o == 9'h000) and
        (fine_code_o == 8'hFF |-> fine_delay_tenth_ps_o == 9'h1F4);
    endproperty
    a_fine_span: assert property (p_fine_span) else $error("fine delay end points wrong");
    property p_coarse_sum;
        coarse_delay_ps_o == coarse_code_o * 12'h041 + int_code_o * 12'h00B;
    endproperty
    a_coarse_sum: assert property (p_coarse_sum) else $error("coarse delay sum wrong");
    property p_write_blank;
        !reg_select_n_i [*4] |-> !strobe_valid_o;
    endproperty
    a_write_blank: assert property (p_write_blank) else $error("strobe valid during a write");
    // hold level is only defined once the synchronisers have caught up
    property p_align_hold;
        strobe_align_pulse_i [*5] |-> !strobe_valid_o && output_data_strobe_o == (ddr_en_i ? 1'b0 : output_edge_i);
    endproperty
    a_align_hold: assert property (p_align_hold) else $error("strobe not held during align");
    property p_release_wait;
        $fell(strobe_align_pulse_i) |-> !strobe_valid_o [*5];
    endproperty
    a_release_wait: assert property (p_release_wait) else $error("strobe restarted too early");
    property p_run_toggle;
        $past(reset_n_i, 2) && !ddr_en_i && strobe_valid_o && $past(strobe_valid_o) && $past(strobe_valid_o, 2)
            |-> output_data_strobe_o != $past(output_data_strobe_o);
    endproperty
    a_run_toggle: assert property (p_run_toggle) else $error("strobe not toggling while valid");
    property p_cal_stop;
        calibration_active_i [*5] |-> !strobe_valid_o && $stable(output_data_strobe_o);
    endproperty
    a_cal_stop: assert property (p_cal_stop) else $error("strobe running during calibration");
    property p_pass;
        $past(reset_n_i) && !pattern_source_select_o && !$past(pattern_source_select_o)
            && !$past(pattern_source_select_o, 2) |-> q_bus_o == $past(adc_q_i);
    endproperty
    a_pass: assert property (p_pass) else $error("converter word not passed through");
    property p_pat_ports;
        pattern_source_select_o && $past(pattern_source_select_o, 3) |-> q_bus_o[6] == i_bus_o[6];
    endproperty
    a_pat_ports: assert property (p_pat_ports) else $error("pattern ports out of step");
    property p_pat_flag;
        pattern_source_select_o && $past(pattern_source_select_o, 3) |-> over_range_o == q_bus_o[6];
    endproperty
    a_pat_flag: assert property (p_pat_flag) else $error("pattern flag does not track high word");
endmodule // scs_checker

bind scs_sample_sync scs_checker scs_checker_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_select_n_i(reg_select_n_i), .ddr_en_i(ddr_en_i),
    .output_edge_i(output_edge_i), .strobe_align_pulse_i(strobe_align_pulse_i),
    .calibration_active_i(calibration_active_i), .adc_q_i(adc_q_i), .fine_code_o(fine_code_o),
    .fine_delay_tenth_ps_o(fine_delay_tenth_ps_o), .coarse_code_o(coarse_code_o), .int_code_o(int_code_o),
    .coarse_delay_ps_o(coarse_delay_ps_o), .output_data_strobe_o(output_data_strobe_o),
    .strobe_valid_o(strobe_valid_o), .q_bus_o(q_bus_o), .i_bus_o(i_bus_o), .over_range_o(over_range_o),
    .pattern_source_select_o(pattern_source_select_o)
);

// >>> bench/scs_ctrl_model.sv
// scs_ctrl_model: system controller driving serial writes and the align pulse
// assumes: serial clock of 125 ns that stands low between frames
`timescale 1ns/10ps
module scs_ctrl_model (
    // clock and status
    input wire sys_clk_i,
    input wire calibration_active_i,
    // pins toward the device
    output reg reg_select_n_o,
    output reg reg_sclk_o,
    output reg reg_sdata_o,
    output reg strobe_align_pulse_o
);
    initial begin
        reg_select_n_o = 1'b1;
        reg_sclk_o = 1'b0;
        reg_sdata_o = 1'b0;
        strobe_align_pulse_o = 1'b0;
    end

    // one register per call keeps the strobe disturbance short
    task write_reg(input [3:0] addr, input [15:0] data, input integer nbits);
        reg [19:0] frame;
        integer k;
        begin
            // odd offset keeps every 62.5 ns serial edge clear of the sample clock edges
            #1.25;
            frame = {addr, data | (addr == 4'hE ? 16'h00FF : addr == 4'hF ? 16'h007F : 16'h03FF)};
            reg_select_n_o = 1'b0;
            #62.5;
            for (k = 19; k > 19 - nbits; k = k - 1) begin
                reg_sdata_o = frame[k];
                #62.5 reg_sclk_o = 1'b1;
                #62.5 reg_sclk_o = 1'b0;
            end
            // released line must not keep showing the last bit
            reg_sdata_o = ~reg_sdata_o;
            #62.5 reg_select_n_o = 1'b1;
            #125;
        end
    endtask

    task align_set;
        integer w;
        begin
            for (w = 0; w < 1000 && calibration_active_i; w = w + 1)
                @(posedge sys_clk_i);
            if (calibration_active_i) begin
                tb_top.err_count = tb_top.err_count + 1;
                $display("MISMATCH align_wait expected 0 seen 1");
                tb_top.end_of_test;
            end
            @(negedge sys_clk_i);
            strobe_align_pulse_o = 1'b1;
        end
    endtask

    task align_release;
        begin
            @(posedge sys_clk_i);
            strobe_align_pulse_o <= 1'b0;
        end
    endtask
endmodule // scs_ctrl_model

// >>> bench/tb_top.sv
// tb_top: self-checking bench for scs_sample_sync
// assumes: controller model in scs_ctrl_model, checker bound to the design
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    checks_done = checks_done + 1; \
    if ((got) !== (ex)) begin \
        err_count = err_count + 1; \
        $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb_top;
    reg sys_clk_i, reset_n_i, demux_en_i, ddr_en_i, dz_i, edge_i, cal_i, or_i;
    reg [6:0] aqd_i, aid_i, aq_i, ai_i;
    wire sel_n, sclk, sdat, align, inv, strobe, valid, orng, pat;
    wire [7:0] fine;
    wire [8:0] tenth;
    wire [4:0] crs;
    wire [2:0] itm;
    wire [11:0] cps;
    wire [6:0] qd, id, q, i;
    integer err_count, checks_done, n, t0, t1, hi;
    reg [67:0] rows [0:5];

    scs_ctrl_model scs_ctrl_model_inst (.sys_clk_i(sys_clk_i), .calibration_active_i(cal_i),
        .reg_select_n_o(sel_n), .reg_sclk_o(sclk), .reg_sdata_o(sdat), .strobe_align_pulse_o(align));
    scs_sample_sync scs_sample_sync_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .reg_select_n_i(sel_n), .reg_sclk_i(sclk), .reg_sdata_i(sdat), .demux_en_i(demux_en_i),
        .ddr_en_i(ddr_en_i), .demux_zero_phase_i(dz_i), .output_edge_i(edge_i), .strobe_align_pulse_i(align),
        .calibration_active_i(cal_i), .adc_qd_i(aqd_i), .adc_id_i(aid_i), .adc_q_i(aq_i), .adc_i_i(ai_i),
        .adc_or_i(or_i), .fine_code_o(fine), .fine_delay_tenth_ps_o(tenth), .coarse_code_o(crs),
        .int_code_o(itm), .coarse_delay_ps_o(cps), .sample_edge_invert_o(inv), .output_data_strobe_o(strobe),
        .strobe_valid_o(valid), .quadrature_delayed_bus_o(qd), .inphase_delayed_bus_o(id), .q_bus_o(q),
        .i_bus_o(i), .over_range_o(orng), .pattern_source_select_o(pat));

    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task wait_valid(output integer cyc);
        begin
            for (cyc = 0; cyc < 40 && valid !== 1'b1; cyc = cyc + 1)
                @(negedge sys_clk_i);
            if (valid !== 1'b1) begin
                err_count = err_count + 1;
                $display("MISMATCH strobe_restart expected 1 seen %b", valid);
                end_of_test;
            end
        end
    endtask

    // mode pins move only under the align pulse so no false strobe edge is seen
    task align_run(input dz, input edg, input ddr, output integer cyc);
        reg s0;
        begin
            scs_ctrl_model_inst.align_set;
            dz_i = dz;
            edge_i = edg;
            ddr_en_i = ddr;
            repeat (8) @(negedge sys_clk_i);
            `CHK("held_strobe", ddr ? 1'b0 : edg, strobe)
            scs_ctrl_model_inst.align_release;
            wait_valid(cyc);
            s0 = strobe;
            @(negedge sys_clk_i);
            if (!ddr)
                `CHK("strobe_toggle", ~s0, strobe)
            $display("align run done, %0d cycles", cyc);
        end
    endtask

    task pass_chk(input [28:0] v);
        begin
            @(negedge sys_clk_i);
            {aqd_i, aid_i, aq_i, ai_i, or_i} = v;
            @(negedge sys_clk_i);
            `CHK("pass_words", v, {qd, id, q, i, orng})
        end
    endtask

    task pat_scan(input [28:0] lo, input [28:0] hw, input integer len);
        integer k;
        reg [28:0] word;
        begin
            hi = 0;
            for (k = 0; k < len; k = k + 1) begin
                @(negedge sys_clk_i);
                word = {qd, id, q, i, orng};
                `CHK("pattern_word", 1'b1, (word === lo) || (word === hw))
                hi = hi + (word === hw);
            end
        end
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        // addr, data, fine, tenths, coarse, intermediate, ps, invert
        rows[0] = 68'hE_FF00_FF_1F4_00_0_000_0;
        rows[1] = 68'hF_FF80_FF_1F4_1F_7_82C_1;
        rows[2] = 68'hE_3300_33_064_1F_7_82C_1;
        rows[3] = 68'hF_0480_33_064_01_1_04C_0;
        rows[4] = 68'hE_0000_00_000_01_1_04C_0;
        rows[5] = 68'h3_FFFF_00_000_01_1_04C_0;
        err_count = 0;
        checks_done = 0;
        {reset_n_i, ddr_en_i, dz_i, edge_i, cal_i} = 5'h00;
        demux_en_i = 1'b1;
        {aqd_i, aid_i, aq_i, ai_i, or_i} = 29'h0000000;
        repeat (10) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        `CHK("reset_regs", 18'h00000, {fine, crs, itm, inv, pat})
        for (n = 0; n < 6; n = n + 1) begin
            fork
                scs_ctrl_model_inst.write_reg(rows[n][67:64], rows[n][63:48], 20);
                begin
                    repeat (30) @(negedge sys_clk_i);
                    `CHK("valid_in_write", 1'b0, valid)
                end
            join
            repeat (5) @(negedge sys_clk_i);
            `CHK("fine_code", rows[n][47:40], fine)
            `CHK("fine_tenths", rows[n][36:28], tenth)
            `CHK("coarse_code", rows[n][24:20], crs)
            `CHK("int_code", rows[n][18:16], itm)
            `CHK("coarse_ps", rows[n][15:4], cps)
            `CHK("invert", rows[n][0], inv)
            $display("row %0d done", n);
        end
        scs_ctrl_model_inst.write_reg(4'hE, 16'hAA00, 19);
        repeat (5) @(negedge sys_clk_i);
        `CHK("short_frame", 8'h00, fine)
        pass_chk({7'h2A, 7'h15, 7'h4C, 7'h33, 1'b1});
        align_run(1'b0, 1'b0, 1'b0, t0);
        align_run(1'b1, 1'b1, 1'b0, t1);
        `CHK("extra_wait", 1, t1 - t0)
        align_run(1'b0, 1'b1, 1'b1, t0);
        cal_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        `CHK("valid_in_cal", 1'b0, valid)
        cal_i = 1'b0;
        scs_ctrl_model_inst.align_set;
        ddr_en_i = 1'b0;
        dz_i = 1'b0;
        scs_ctrl_model_inst.write_reg(4'h9, 16'h8000, 20);
        repeat (5) @(negedge sys_clk_i);
        `CHK("pattern_sel", 1'b1, pat)
        `CHK("pattern_held", {7'h00, 7'h01, 7'h01, 7'h02, 1'b0}, {qd, id, q, i, orng})
        scs_ctrl_model_inst.align_release;
        wait_valid(t0);
        // two high steps of five, each held for two sample clocks, in any 20 cycles
        pat_scan({7'h00, 7'h01, 7'h01, 7'h02, 1'b0}, {7'h7F, 7'h7E, 7'h7E, 7'h7D, 1'b1}, 20);
        `CHK("demux_highs", 8, hi)
        scs_ctrl_model_inst.align_set;
        demux_en_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        scs_ctrl_model_inst.align_release;
        wait_valid(t0);
        repeat (3) @(negedge sys_clk_i);
        pat_scan({7'h00, 7'h00, 7'h00, 7'h01, 1'b0}, {7'h00, 7'h00, 7'h7F, 7'h7E, 1'b1}, 12);
        `CHK("nodemux_highs", 5, hi)
        scs_ctrl_model_inst.write_reg(4'h9, 16'h0000, 20);
        repeat (5) @(negedge sys_clk_i);
        pass_chk({7'h11, 7'h22, 7'h33, 7'h44, 1'b0});
        end_of_test;
    end
endmodule // tb_top
